// *** common/cstr_pkg.sv ***
// Operation
// R1 - Six-entry return address store, program counter values only, no software access.
// R2 - Call or interrupt acknowledge saves the PC at the index, then index plus one.
// R3 - Return reloads the PC from the last saved entry, index minus one.
// R4 - Index is zero after reset and reads zero when all six entries are full.
// R5 - Full store: interrupt flag still set, acknowledge withheld until a return.
// R6 - Call on full store still proceeds, losing the oldest saved PC.
// R7 - Index register read-only, index in bits 2..0, upper bits zero, reset zero.
// R8 - Index counts modulo six in both directions.
// R9 - ALU result goes to its target and the status flags are updated.
// R10 - ALU does add, subtract, decimal adjust, logic, rotates, inc, dec, skip tests. The ALU here has no skip tests.
// R11 - Program memory is 4K words of 16 bits, fetch and table read anywhere.
// R12 - Reset loads the PC with 000H and execution starts there.
// R13 - Table address is formed from the low and high table pointer bytes.
// R14 - Table read: low byte to named data register, high byte to table_high_byte.
// R15 - Normal table reads target sector 0; extended variants reach other sectors.
// R16 - Every table instruction takes two instruction cycles.
// R17 - table_high_byte is readable and writable by software.
// R18 - Instruction cycle is four phases; PC advances and fetch happens in the first.
// R19 - PC is 12 bits; PC loads cost one extra cycle for the discarded fetch.
// R20 - Second table read cycle uses the memory port and holds the sequence.
// R21 - Stack entries are a circular buffer indexed by the level index.
package cstr_pkg;
	localparam int unsigned STACK_DEPTH   = 6;
	localparam int unsigned PC_W          = 12;
	localparam int unsigned WORD_W        = 16;
	localparam int unsigned PHASES        = 4;
	localparam logic [11:0] RESET_VECTOR  = 12'h000;
	// Register byte addresses on the bus
	localparam logic [7:0]  ADDR_LEVEL    = 8'h00;
	localparam logic [7:0]  ADDR_TBL_LO   = 8'h04;
	localparam logic [7:0]  ADDR_TBL_HI   = 8'h08;
	localparam logic [7:0]  ADDR_TBL_HB   = 8'h0C;
	localparam logic [7:0]  ADDR_PC       = 8'h10;
	localparam logic [7:0]  ADDR_STATUS   = 8'h14;
	localparam logic [7:0]  ADDR_SECTOR   = 8'h18;
	// Status flag positions
	localparam int unsigned FLAG_C  = 0;
	localparam int unsigned FLAG_AC = 1;
	localparam int unsigned FLAG_Z  = 2;
	localparam int unsigned FLAG_OV = 3;
	typedef enum logic [3:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
		ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_PASS
	} cstr_alu_op_t;
	typedef enum logic [1:0] {ST_RUN, ST_FLUSH, ST_TBL} cstr_seq_t;
endpackage : cstr_pkg

// *** rtl/cstr_core.sv ***
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module cstr_core (
	// Clock and reset
	input  wire logic                    clk_in,
	input  wire logic                    nrst_in,
	// AHB-Lite slave
	input  wire logic                    hsel_in,
	input  wire logic [31:0]             haddr_in,
	input  wire logic [1:0]              htrans_in,
	input  wire logic                    hwrite_in,
	input  wire logic [2:0]              hsize_in,
	input  wire logic [31:0]             hwdata_in,
	input  wire logic                    hready_in,
	output logic      [31:0]             hrdata_out,
	output logic                         hreadyout_out,
	output logic                         hresp_out,
	// Sequencer controls, sampled at the first phase
	input  wire logic                    call_in,
	input  wire logic [11:0]             call_target_in,
	input  wire logic                    return_from_sub_in,
	input  wire logic                    return_from_irq_in,
	input  wire logic                    irq_pending_in,
	input  wire logic [11:0]             irq_vector_in,
	input  wire logic                    table_fetch_in,
	input  wire logic                    ext_table_fetch_in,
	input  wire logic [7:0]              table_dest_in,
	// ALU request
	input  wire logic                    alu_valid_in,
	input  wire cstr_pkg::cstr_alu_op_t  alu_op_in,
	input  wire logic [7:0]              alu_a_in,
	input  wire logic [7:0]              alu_b_in,
	output logic      [7:0]              alu_result_out,
	output logic                         alu_result_valid_out,
	// Program memory port
	output logic      [11:0]             pmem_addr_out,
	input  wire logic [15:0]             pmem_data_in,
	// Sequencer outputs
	output logic      [11:0]             pc_out,
	output logic                         phase1_out,
	output logic                         irq_ack_out,
	output logic                         stall_out,
	output logic                         table_wr_out,
	output logic      [7:0]              table_wr_addr_out,
	output logic      [1:0]              table_wr_sector_out,
	output logic      [7:0]              table_wr_data_out
);
	localparam int unsigned D = cstr_pkg::STACK_DEPTH;
	// Index arithmetic is three bits wide and wraps after the sixth entry
	if (D != 6) begin : g_bad_depth
		$error("cstr_core: stack depth must be six");
	end
	if (cstr_pkg::PC_W != 12) begin : g_bad_pc
		$error("cstr_core: program counter must be twelve bits");
	end

	function automatic logic [2:0] idx_inc(input logic [2:0] i);
		idx_inc = (i == 3'(D - 1)) ? 3'h0 : 3'(i + 3'h1); // R8
	endfunction : idx_inc
	function automatic logic [2:0] idx_dec(input logic [2:0] i);
		idx_dec = (i == 3'h0) ? 3'(D - 1) : 3'(i - 3'h1); // R8
	endfunction : idx_dec

	logic [11:0]           stack_q [D];
	logic [2:0]            level_q;
	logic                  full_q;
	logic [11:0]           pc_q;
	logic [1:0]            phase_q;
	cstr_pkg::cstr_seq_t   seq_q;
	logic [7:0]            tbl_lo_q;
	logic [7:0]            tbl_hi_q;
	logic [7:0]            table_high_byte_q;
	logic [1:0]            sector_q;
	logic [7:0]            dest_q;
	logic [7:0]            status_q;
	logic [7:0]            alu_res_q;
	logic                  alu_v_q;
	logic                  tw_q;
	logic [7:0]            tw_data_q;
	logic                  ack_q;
	// Set once the first stalled instruction cycle has run out
	logic                  tail_q;
	// Bus data-phase state
	logic                  dp_wr_q;
	logic                  dp_rd_q;
	logic [7:0]            dp_addr_q;
	logic [31:0]           rdata_q;

	// Sequencer decode at the start of each instruction cycle
	wire phase1      = (phase_q == 2'h0);
	wire cyc_end     = (phase_q == 2'(cstr_pkg::PHASES - 1));
	wire run         = (seq_q == cstr_pkg::ST_RUN);
	wire do_ret      = run && phase1 && (return_from_sub_in || return_from_irq_in);
	// A full store holds off the acknowledge; the pending flag itself lives outside
	wire do_ack      = run && phase1 && irq_pending_in && !full_q && !do_ret; // R5
	wire do_call     = run && phase1 && call_in && !do_ack && !do_ret; // R6
	wire do_tbl      = run && phase1 && (table_fetch_in || ext_table_fetch_in) && !do_ack && !do_ret && !call_in;
	wire do_push     = do_call || do_ack; // R2
	wire [2:0] top   = idx_dec(level_q);
	// Only the low nibble of the high pointer reaches the twelve-bit address
	wire [11:0] tbl_addr = {tbl_hi_q[3:0], tbl_lo_q}; // R13

	// Bus address decode
	wire        ap_valid = hsel_in && hready_in && htrans_in[1];
	wire        ap_wr    = ap_valid && hwrite_in;
	wire        ap_rd    = ap_valid && !hwrite_in;
	wire        hit_lo   = (dp_addr_q == cstr_pkg::ADDR_TBL_LO);
	wire        hit_hi   = (dp_addr_q == cstr_pkg::ADDR_TBL_HI);
	wire        hit_hb   = (dp_addr_q == cstr_pkg::ADDR_TBL_HB);
	wire        hit_sec  = (dp_addr_q == cstr_pkg::ADDR_SECTOR);
	wire [7:0]  ra       = haddr_in[7:0];
	wire [31:0] rd_mux   = (ra == cstr_pkg::ADDR_LEVEL)  ? {29'h0, level_q} : // R7
	                       (ra == cstr_pkg::ADDR_TBL_LO) ? {24'h0, tbl_lo_q} :
	                       (ra == cstr_pkg::ADDR_TBL_HI) ? {24'h0, tbl_hi_q} :
	                       (ra == cstr_pkg::ADDR_TBL_HB) ? {24'h0, table_high_byte_q} : // R17
	                       (ra == cstr_pkg::ADDR_PC)     ? {20'h0, pc_q} :
	                       (ra == cstr_pkg::ADDR_STATUS) ? {24'h0, status_q} :
	                       (ra == cstr_pkg::ADDR_SECTOR) ? {30'h0, sector_q} : 32'h0000_0000;

	// ALU: 9-bit sums give carry; nibble sums give aux carry
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] res;
	logic       cout;
	logic       ovf;
	always_comb begin
		sum  = 9'h000;
		nib  = 5'h00;
		res  = 8'h00;
		cout = status_q[cstr_pkg::FLAG_C];
		ovf  = status_q[cstr_pkg::FLAG_OV];
		case (alu_op_in) // R10
			cstr_pkg::ALU_ADD, cstr_pkg::ALU_ADC: begin
				sum  = {1'b0, alu_a_in} + {1'b0, alu_b_in}
				       + {8'h00, (alu_op_in == cstr_pkg::ALU_ADC) & status_q[cstr_pkg::FLAG_C]};
				nib  = {1'b0, alu_a_in[3:0]} + {1'b0, alu_b_in[3:0]};
				res  = sum[7:0];
				cout = sum[8];
				ovf  = (alu_a_in[7] == alu_b_in[7]) && (res[7] != alu_a_in[7]);
			end
			cstr_pkg::ALU_SUB, cstr_pkg::ALU_SBC: begin
				// Carry set means no borrow
				sum  = {1'b0, alu_a_in} + {1'b0, ~alu_b_in}
				       + {8'h00, (alu_op_in == cstr_pkg::ALU_SUB) | status_q[cstr_pkg::FLAG_C]};
				nib  = {1'b0, alu_a_in[3:0]} + {1'b0, ~alu_b_in[3:0]} + 5'h01;
				res  = sum[7:0];
				cout = sum[8];
				ovf  = (alu_a_in[7] != alu_b_in[7]) && (res[7] != alu_a_in[7]);
			end
			cstr_pkg::ALU_DAA: begin
				sum = {1'b0, alu_a_in};
				if (alu_a_in[3:0] > 4'h9 || status_q[cstr_pkg::FLAG_AC]) sum = sum + 9'h006;
				if (sum[8:4] > 5'h09 || status_q[cstr_pkg::FLAG_C]) sum = sum + 9'h060;
				res  = sum[7:0];
				cout = sum[8] | status_q[cstr_pkg::FLAG_C];
			end
			cstr_pkg::ALU_AND: res = alu_a_in & alu_b_in;
			cstr_pkg::ALU_OR:  res = alu_a_in | alu_b_in;
			cstr_pkg::ALU_XOR: res = alu_a_in ^ alu_b_in;
			cstr_pkg::ALU_CPL: res = ~alu_a_in;
			cstr_pkg::ALU_RR:  res = {alu_a_in[0], alu_a_in[7:1]};
			cstr_pkg::ALU_RL:  res = {alu_a_in[6:0], alu_a_in[7]};
			cstr_pkg::ALU_RRC: begin
				res  = {status_q[cstr_pkg::FLAG_C], alu_a_in[7:1]};
				cout = alu_a_in[0];
			end
			cstr_pkg::ALU_RLC: begin
				res  = {alu_a_in[6:0], status_q[cstr_pkg::FLAG_C]};
				cout = alu_a_in[7];
			end
			cstr_pkg::ALU_INC: res = alu_a_in + 8'h01;
			cstr_pkg::ALU_DEC: res = alu_a_in - 8'h01;
			default:           res = alu_a_in;
		endcase
	end
	// Status byte: overflow, zero, aux carry and carry in bits 3 to 0, upper bits zero
	wire [7:0] status_d = {4'h0, ovf, (res == 8'h00), nib[4], cout};

	// Stack and level index
	// A pop from an empty store wraps to the top entry, as the index does
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			level_q <= 3'h0; // R4
			full_q  <= 1'b0;
			for (int i = 0; i < D; i++) stack_q[i] <= 12'h000;
		end else if (do_push) begin
			stack_q[level_q] <= pc_q; // R1 R21
			level_q <= idx_inc(level_q); // R2 R8
			full_q  <= full_q || (level_q == 3'(D - 1)); // R4
		end else if (do_ret) begin
			level_q <= top; // R3 R8
			full_q  <= 1'b0;
		end
	end

	// Phase counter, program counter and sequencer
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			phase_q <= 2'h0;
			pc_q    <= cstr_pkg::RESET_VECTOR; // R12
			seq_q   <= cstr_pkg::ST_RUN;
			dest_q  <= 8'h00;
			ack_q   <= 1'b0;
			tail_q  <= 1'b0;
		end else begin
			phase_q <= cyc_end ? 2'h0 : 2'(phase_q + 2'h1); // R18
			ack_q   <= do_ack;
			if (do_ret) begin
				pc_q  <= stack_q[top]; // R3
				seq_q <= cstr_pkg::ST_FLUSH; // R19
			end else if (do_ack) begin
				pc_q  <= irq_vector_in;
				seq_q <= cstr_pkg::ST_FLUSH; // R19
			end else if (do_call) begin
				pc_q  <= call_target_in;
				seq_q <= cstr_pkg::ST_FLUSH; // R19
			end else if (do_tbl) begin
				pc_q   <= 12'(pc_q + 12'h001); // R18
				dest_q <= table_dest_in;
				seq_q  <= cstr_pkg::ST_TBL; // R16
			end else if (run && phase1) begin
				pc_q <= 12'(pc_q + 12'h001); // R18
			end else if (cyc_end && !run) begin
				// The stall covers the rest of this cycle and one whole cycle after it
				if (tail_q) begin
					seq_q  <= cstr_pkg::ST_RUN; // R19
					tail_q <= 1'b0;
				end else begin
					tail_q <= 1'b1; // R16
				end
			end
		end
	end

	// Table fetch, ALU flags and bus registers
	// The word is taken at the end of the second table cycle
	wire tbl_cap = (seq_q == cstr_pkg::ST_TBL) && tail_q && cyc_end; // R16 R20
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			table_high_byte_q <= 8'h00;
			tbl_lo_q  <= 8'h00;
			tbl_hi_q  <= 8'h00;
			sector_q  <= 2'h0;
			tw_q      <= 1'b0;
			tw_data_q <= 8'h00;
			status_q  <= 8'h00;
			alu_res_q <= 8'h00;
			alu_v_q   <= 1'b0;
			dp_wr_q   <= 1'b0;
			dp_rd_q   <= 1'b0;
			dp_addr_q <= 8'h00;
			rdata_q   <= 32'h0000_0000;
		end else begin
			tw_q    <= tbl_cap;
			alu_v_q <= alu_valid_in;
			dp_wr_q <= ap_wr;
			dp_rd_q <= ap_rd;
			if (ap_valid) dp_addr_q <= ra;
			if (ap_rd) rdata_q <= rd_mux;
			// Flags move only when an operation is issued, so idle cycles keep them
			if (alu_valid_in) begin
				alu_res_q <= res; // R9
				status_q  <= status_d; // R9
			end
			// Hardware table load takes priority over a software write in the same cycle
			if (tbl_cap) begin
				tw_data_q         <= pmem_data_in[7:0]; // R14
				table_high_byte_q <= pmem_data_in[15:8]; // R14
			end else if (dp_wr_q && hit_hb) begin
				table_high_byte_q <= hwdata_in[7:0]; // R17
			end
			if (dp_wr_q && hit_lo) tbl_lo_q <= hwdata_in[7:0];
			if (dp_wr_q && hit_hi) tbl_hi_q <= hwdata_in[7:0];
			if (dp_wr_q && hit_sec) sector_q <= hwdata_in[1:0];
		end
	end

	// Extended flag of the last table fetch request, normal or extended
	logic ext_q;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) ext_q <= 1'b0;
		else if (do_tbl) ext_q <= ext_table_fetch_in;
	end

	// The table address owns the port only in the second table cycle; flush cycles and the first table cycle fetch from the PC
	assign pmem_addr_out        = (seq_q == cstr_pkg::ST_TBL && tail_q) ? tbl_addr : pc_q; // R11 R20
	assign stall_out            = !run; // R20
	assign pc_out               = pc_q;
	assign phase1_out           = phase1;
	assign irq_ack_out          = ack_q;
	assign table_wr_out         = tw_q;
	assign table_wr_addr_out    = dest_q;
	assign table_wr_sector_out  = ext_q ? sector_q : 2'h0; // R15
	assign table_wr_data_out    = tw_data_q;
	assign alu_result_out       = alu_res_q;
	assign alu_result_valid_out = alu_v_q;
	// Outside the data phase the read bus shows zero
	assign hrdata_out           = dp_rd_q ? rdata_q : 32'h0000_0000;
	assign hreadyout_out        = 1'b1;
	assign hresp_out            = 1'b0;
endmodule : cstr_core

// *** tb/cstr_pmem_model.sv ***
`timescale 1ns/10ps
module cstr_pmem_model (
	// Fetch address
	input  wire logic [11:0] addr_in,
	// Word out
	output logic      [15:0] data_out
);
	// Every word differs, so any wrong table address shows up in the data
	assign data_out = {4'h5, addr_in};
endmodule : cstr_pmem_model

// *** tb/cstr_core_sva.sv ***
`timescale 1ns/10ps
module cstr_core_sva (
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        nrst_in,
	// Sequencer
	input wire logic        call_in,
	input wire logic [11:0] call_target_in,
	input wire logic        return_from_sub_in,
	input wire logic        return_from_irq_in,
	input wire logic        irq_pending_in,
	input wire logic [11:0] irq_vector_in,
	input wire logic        table_fetch_in,
	input wire logic [15:0] pmem_data_in,
	input wire logic [11:0] pc_out,
	input wire logic        phase1_out,
	input wire logic        irq_ack_out,
	input wire logic        stall_out,
	input wire logic        table_wr_out,
	input wire logic [7:0]  table_wr_data_out,
	// ALU
	input wire logic        alu_valid_in,
	input wire logic        alu_result_valid_out
);
	wire logic       go;
	wire logic       quiet;
	wire logic [7:0] mem_lo;
	assign go = phase1_out && !stall_out;
	assign quiet = !return_from_sub_in && !return_from_irq_in && !irq_pending_in;
	assign mem_lo = pmem_data_in[7:0];
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	sequence s_call;
		go && call_in && quiet;
	endsequence
	sequence s_table;
		go && table_fetch_in && !call_in && quiet;
	endsequence
	sequence s_hold7;
		stall_out[*7];
	endsequence
	a_phase_period: assert property (phase1_out |=> !phase1_out[*3] ##1 phase1_out)
		else $error("phase strobe period wrong");
	a_pc_hold: assert property (!phase1_out |=> $stable(pc_out))
		else $error("pc moved outside first phase");
	a_call_target: assert property (s_call |=> pc_out == $past(call_target_in))
		else $error("call did not load target");
	a_call_flush: assert property (s_call |=> s_hold7 ##1 go)
		else $error("call flush length wrong");
	a_table_cycles: assert property (s_table |=> s_hold7 ##1 (go && table_wr_out))
		else $error("table read length wrong");
	a_table_low: assert property (table_wr_out |-> table_wr_data_out == $past(mem_lo))
		else $error("table low byte wrong");
	a_irq_vector: assert property (irq_ack_out |-> pc_out == $past(irq_vector_in) && $past(irq_pending_in))
		else $error("interrupt entry wrong");
	a_alu_answer: assert property (alu_valid_in |=> alu_result_valid_out)
		else $error("alu result late");
endmodule : cstr_core_sva
bind cstr_core cstr_core_sva u_sva (.clk_in, .nrst_in, .call_in, .call_target_in, .return_from_sub_in,
	.return_from_irq_in, .irq_pending_in, .irq_vector_in, .table_fetch_in, .pmem_data_in, .pc_out, .phase1_out,
	.irq_ack_out, .stall_out, .table_wr_out, .table_wr_data_out, .alu_valid_in, .alu_result_valid_out);

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
	logic                   clk_in, nrst_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
	logic [31:0]            haddr_in, hwdata_in, hrdata_out;
	logic [1:0]             htrans_in, table_wr_sector_out;
	logic [2:0]             hsize_in;
	logic                   call_in, return_from_sub_in, return_from_irq_in, irq_pending_in, table_fetch_in;
	logic                   ext_table_fetch_in, alu_valid_in, alu_result_valid_out, phase1_out, irq_ack_out;
	logic                   stall_out, table_wr_out;
	logic [11:0]            call_target_in, irq_vector_in, pmem_addr_out, pc_out;
	logic [7:0]             table_dest_in, alu_a_in, alu_b_in, alu_result_out, table_wr_addr_out, table_wr_data_out;
	logic [15:0]            pmem_data_in;
	cstr_pkg::cstr_alu_op_t alu_op_in;
	int                     n_errors, samples_checked, i, n;
	logic [31:0]            status_seen;
	assign hready_in = hreadyout_out;
	cstr_core DUT (.clk_in, .nrst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in,
		.hrdata_out, .hreadyout_out, .hresp_out, .call_in, .call_target_in, .return_from_sub_in, .return_from_irq_in,
		.irq_pending_in, .irq_vector_in, .table_fetch_in, .ext_table_fetch_in, .table_dest_in, .alu_valid_in,
		.alu_op_in, .alu_a_in, .alu_b_in, .alu_result_out, .alu_result_valid_out, .pmem_addr_out, .pmem_data_in,
		.pc_out, .phase1_out, .irq_ack_out, .stall_out, .table_wr_out, .table_wr_addr_out, .table_wr_sector_out,
		.table_wr_data_out);
	cstr_pmem_model u_mem (.addr_in(pmem_addr_out), .data_out(pmem_data_in));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	task complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			n_errors++;
		end
	endtask : chk
	task automatic hung(input logic bad);
		if (bad) begin
			$display("ERROR wait timed out");
			n_errors++;
			complete_run;
		end
	endtask : hung
	task automatic rdy;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (hreadyout_out !== 1'b1 && n < 50);
		hung(hreadyout_out !== 1'b1);
	endtask : rdy
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_in);
		hsel_in <= 1'b1;
		haddr_in <= {24'h000000, a};
		htrans_in <= 2'b10;
		hwrite_in <= w;
		hsize_in <= 3'b010;
		rdy;
		htrans_in <= 2'b00;
		hwdata_in <= d;
		rdy;
		q = hrdata_out;
		hsel_in <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk(s, e, q);
		chk("bus response", 32'h0, {31'h0, hresp_out});
	endtask : rd
	// Bits are {from_irq, from_sub, call, table, ext_table}; held until the taking edge
	task automatic seq(input logic [4:0] k, input logic [11:0] t);
		@(posedge clk_in);
		{return_from_irq_in, return_from_sub_in, call_in, table_fetch_in, ext_table_fetch_in} <= k;
		call_target_in <= t;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (!(phase1_out === 1'b1 && stall_out === 1'b0) && n < 20);
		hung(!(phase1_out === 1'b1 && stall_out === 1'b0));
		@(posedge clk_in);
		{return_from_irq_in, return_from_sub_in, call_in, table_fetch_in, ext_table_fetch_in} <= 5'h00;
	endtask : seq
	task automatic await(ref logic s);
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (s !== 1'b1 && n < 40);
		hung(s !== 1'b1);
	endtask : await
	task automatic alu(input cstr_pkg::cstr_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] e);
		@(posedge clk_in);
		alu_valid_in <= 1'b1;
		alu_op_in <= op;
		alu_a_in <= a;
		alu_b_in <= b;
		@(posedge clk_in);
		alu_valid_in <= 1'b0;
		@(negedge clk_in);
		chk("alu result", {24'h000000, e}, {24'h000000, alu_result_out});
	endtask : alu
	initial begin
		{nrst_in, hsel_in, hwrite_in, call_in, return_from_sub_in, return_from_irq_in, irq_pending_in} = '0;
		{table_fetch_in, ext_table_fetch_in, alu_valid_in, haddr_in, hwdata_in, htrans_in, hsize_in} = '0;
		{call_target_in, irq_vector_in, table_dest_in, alu_a_in, alu_b_in} = '0;
		alu_op_in = cstr_pkg::ALU_ADD;
		n_errors = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(negedge clk_in);
		chk("reset pc", 32'h0, {20'h0, pc_out});
		chk("reset fetch address", 32'h0, {20'h0, pmem_addr_out});
		// The first edge after release is a first phase, so the bus sees the PC one step on
		rd(cstr_pkg::ADDR_PC, 32'h1, "pc after first fetch");
		rd(cstr_pkg::ADDR_LEVEL, 32'h0, "reset level");
		$display("test reset done");
		for (i = 1; i <= 6; i++) begin
			seq(5'b00100, 12'h100 + i[11:0]);
			rd(cstr_pkg::ADDR_LEVEL, i % 6, "call level");
		end
		// Store is full now: the pending interrupt has to wait for a return
		irq_pending_in <= 1'b1;
		irq_vector_in <= 12'h004;
		for (i = 0; i < 16; i++) begin
			@(negedge clk_in);
			chk("ack while full", 32'h0, {31'h0, irq_ack_out});
		end
		seq(5'b10000, 12'h000);
		await(irq_ack_out);
		chk("irq entry", 32'h004, {20'h0, pc_out});
		@(posedge clk_in);
		irq_pending_in <= 1'b0;
		rd(cstr_pkg::ADDR_LEVEL, 32'h0, "level full again");
		for (i = 1; i <= 6; i++) begin
			seq(5'b01000, 12'h000);
			rd(cstr_pkg::ADDR_LEVEL, 6 - i, "return level");
		end
		$display("test stack done");
		wr(cstr_pkg::ADDR_TBL_LO, 32'h06);
		wr(cstr_pkg::ADDR_TBL_HI, 32'h0F);
		wr(cstr_pkg::ADDR_SECTOR, 32'h2);
		table_dest_in <= 8'h23;
		for (i = 0; i < 2; i++) begin
			seq(i ? 5'b00001 : 5'b00010, 12'h000);
			await(table_wr_out);
			chk("table dest", 32'h23, {24'h0, table_wr_addr_out});
			chk("table sector", i ? 2 : 0, {30'h0, table_wr_sector_out});
			chk("table low", 32'h06, {24'h0, table_wr_data_out});
			rd(cstr_pkg::ADDR_TBL_HB, 32'h5F, "table high");
		end
		wr(cstr_pkg::ADDR_TBL_HB, 32'hA5);
		rd(cstr_pkg::ADDR_TBL_HB, 32'hA5, "high byte rw");
		wr(cstr_pkg::ADDR_LEVEL, 32'hFF);
		rd(cstr_pkg::ADDR_LEVEL, 32'h0, "level read only");
		rd(8'h40, 32'h0, "unmapped");
		$display("test table done");
		alu(cstr_pkg::ALU_ADD, 8'h0F, 8'h01, 8'h10);
		alu(cstr_pkg::ALU_XOR, 8'hA5, 8'hFF, 8'h5A);
		alu(cstr_pkg::ALU_DEC, 8'h00, 8'h00, 8'hFF);
		alu(cstr_pkg::ALU_SUB, 8'h05, 8'h05, 8'h00);
		bus(1'b0, cstr_pkg::ADDR_STATUS, 32'h0, status_seen);
		chk("zero and no borrow", 32'h5, status_seen & 32'h5);
		$display("test alu done");
		complete_run;
	end
endmodule : testbench
